// ===== verilog/sspf_pkg.sv
// constants for the serial sram slave pin framing block
// assumes a 125 MHz system clock sampling all serial pins

package sspf_pkg;

    // ------------------------------------------------------------
    // clocking and durations
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int RECALL_US = 50;
    localparam int RESTORE_US = 200;
    // longest times, rounded down (exact here)
    localparam int RECALL_CYC = RECALL_US * CLK_MHZ;
    localparam int RESTORE_CYC = RESTORE_US * CLK_MHZ;

    // ------------------------------------------------------------
    // pin positions in the synchroniser vector
    // ------------------------------------------------------------
    localparam int PIN_CS = 0;
    localparam int PIN_SCK = 1;
    localparam int PIN_SI = 2;
    localparam int PIN_NUM = 3;

    // ------------------------------------------------------------
    // operation codes and frame layout
    // ------------------------------------------------------------
    localparam logic [7:0] OP_WRITE = 8'h02;
    localparam logic [7:0] OP_READ = 8'h03;
    localparam logic [1:0] BYTE_DATA = 2'h3;
    localparam logic [2:0] BIT_LAST = 3'h7;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] OPCODE_RST = 8'h00;
    localparam logic [15:0] CNT_RST = 16'h0000;

endpackage : sspf_pkg

// ===== verilog/sspf_pin_sync.sv
// two-flop synchroniser with edge detection for the serial pins
// assumes pins are asynchronous to mclk_i and slower than mclk_i / 4

`timescale 1ns/100ps

module sspf_pin_sync #(
    parameter int W = 3
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // raw pins
    input wire logic [W-1:0] pin_i,
    // synchronised level and one-cycle edge pulses
    output logic [W-1:0] lvl_o,
    output logic [W-1:0] rise_o,
    output logic [W-1:0] fall_o
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] lvl;
        logic [W-1:0] rise;
        logic [W-1:0] fall;
    } sspf_sync_t;

    if (W < 1) begin : g_bad_w
        $error("pin count must be at least 1");
    end

    sspf_sync_t st_r;
    sspf_sync_t st_nxt;
    logic [W-1:0] rise_w;
    logic [W-1:0] fall_w;

    // ------------------------------------------------------------
    // edge detection looks only at the second and level stages
    // ------------------------------------------------------------
    for (genvar g = 0; g < W; g++) begin : g_edge
        assign rise_w[g] = st_r.s2[g] & ~st_r.lvl[g];
        assign fall_w[g] = ~st_r.s2[g] & st_r.lvl[g];
    end

    always_comb begin
        st_nxt = st_r;
        st_nxt.s1 = pin_i;
        st_nxt.s2 = st_r.s1;
        st_nxt.lvl = st_r.s2;
        st_nxt.rise = rise_w;
        st_nxt.fall = fall_w;
    end

    // reset pin stages to all ones and edge pulses to zero: chip select idles high (deselected)
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '1;
            st_r.rise <= '0;
            st_r.fall <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign lvl_o = st_r.lvl;
    assign rise_o = st_r.rise;
    assign fall_o = st_r.fall;

endmodule : sspf_pin_sync

// ===== verilog/sspf_frame.sv
// serial sram slave pin framing: select, shift in/out, commit, busy
// assumes an spi master in mode 0 or 3 with sck well below mclk_i / 4

`timescale 1ns/100ps

// Notes on behaviour
// - only take part while select is low
// - select high deselects, ends the sequence
// - output released to high-z while deselected
// - select rising after write commits the write
// - ignore bus until first select falling edge seen while not busy
// - sample input on each clock rising edge
// - shift next output bit after falling edge
// - software recall finishes within 50 us
// - power-up restore finishes within 200 us
// - all bytes shift most significant bit first
// - first byte after select is the opcode
module sspf_frame #(
    parameter int RECALL_CYC = sspf_pkg::RECALL_CYC,
    parameter int RESTORE_CYC = sspf_pkg::RESTORE_CYC
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // serial pins
    input wire logic cs_b_i,
    input wire logic sck_i,
    input wire logic si_i,
    output logic so_o,
    output logic so_oe_b_o,
    // core side
    input wire logic recall_req_i,
    input wire logic [7:0] rd_byte_i,
    output logic rd_req_o,
    output logic [7:0] opcode_o,
    output logic opcode_vld_o,
    output logic [7:0] byte_o,
    output logic byte_vld_o,
    output logic wr_commit_o,
    output logic busy_o
);

    // the busy timer is 16 bits wide and one counter serves both
    // durations, so recall may not exceed the restore bound
    if (RECALL_CYC < 1 || RECALL_CYC > 65535 ||
        RESTORE_CYC < 1 || RESTORE_CYC > 65535 ||
        RECALL_CYC > RESTORE_CYC) begin : g_bad_cyc
        $error("busy counts must lie in 1..65535, recall <= restore");
    end

    typedef struct packed {
        logic armed;
        logic sel;
        logic [2:0] bitcnt;
        logic [1:0] bytecnt;
        logic [7:0] opcode;
        logic [7:0] shreg;
        logic [7:0] txreg;
        logic so;
        logic so_oe_b;
        logic wr_pend;
        logic op_vld;
        logic [7:0] rx_byte;
        logic byte_vld;
        logic commit;
        logic rd_req;
        logic [15:0] cnt;
        logic busy;
    } sspf_state_t;

    sspf_state_t st_r;
    sspf_state_t st_nxt;
    logic [2:0] lvl_w;
    logic [2:0] rise_w;
    logic [2:0] fall_w;
    logic cs_hi;
    logic cs_fall;
    logic cs_rise;
    logic sck_rise;
    logic sck_fall;
    logic si_s;
    logic sel_now;
    logic rd_phase;
    logic [7:0] rx_val;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    sspf_pin_sync #(
        .W(sspf_pkg::PIN_NUM)
    ) u_sync (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .pin_i({si_i, sck_i, cs_b_i}),
        .lvl_o(lvl_w),
        .rise_o(rise_w),
        .fall_o(fall_w)
    );

    assign cs_hi = lvl_w[sspf_pkg::PIN_CS];
    assign cs_fall = fall_w[sspf_pkg::PIN_CS];
    assign cs_rise = rise_w[sspf_pkg::PIN_CS];
    assign sck_rise = rise_w[sspf_pkg::PIN_SCK];
    assign sck_fall = fall_w[sspf_pkg::PIN_SCK];
    assign si_s = lvl_w[sspf_pkg::PIN_SI];

    // a falling select seen this cycle arms at once so an early
    // clock edge is not lost
    assign sel_now = !cs_hi && !st_r.busy && (st_r.armed || cs_fall);
    assign rd_phase = st_r.opcode == sspf_pkg::OP_READ &&
                      st_r.bytecnt == sspf_pkg::BYTE_DATA;
    assign rx_val = {st_r.shreg[6:0], si_s};

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.op_vld = 1'b0;
        st_nxt.byte_vld = 1'b0;
        st_nxt.commit = 1'b0;
        st_nxt.rd_req = 1'b0;
        // busy timer for restore and recall
        if (st_r.cnt != sspf_pkg::CNT_RST) begin
            st_nxt.cnt = st_r.cnt - 16'h0001;
        end else if (recall_req_i) begin
            st_nxt.cnt = RECALL_CYC[15:0];
        end
        st_nxt.busy = st_nxt.cnt != sspf_pkg::CNT_RST;
        if (cs_fall && !st_r.busy) begin
            st_nxt.armed = 1'b1;
        end
        if (cs_hi) begin
            // standby: drop the frame and release the output
            st_nxt.sel = 1'b0;
            st_nxt.bitcnt = 3'h0;
            st_nxt.bytecnt = 2'h0;
            st_nxt.opcode = sspf_pkg::OPCODE_RST;
            st_nxt.so_oe_b = 1'b1;
            st_nxt.so = 1'b0;
            st_nxt.wr_pend = 1'b0;
            st_nxt.commit = cs_rise && st_r.wr_pend;
        end else begin
            st_nxt.sel = sel_now;
            if (sel_now && sck_rise) begin
                st_nxt.shreg = rx_val;
                st_nxt.bitcnt = st_r.bitcnt + 3'h1;
                if (st_r.bitcnt == sspf_pkg::BIT_LAST) begin
                    if (st_r.bytecnt == 2'h0) begin
                        st_nxt.opcode = rx_val;
                        st_nxt.op_vld = 1'b1;
                    end else begin
                        st_nxt.rx_byte = rx_val;
                        st_nxt.byte_vld = 1'b1;
                        if (st_r.bytecnt == sspf_pkg::BYTE_DATA &&
                            st_r.opcode == sspf_pkg::OP_WRITE) begin
                            st_nxt.wr_pend = 1'b1;
                        end
                    end
                    if (st_r.bytecnt != sspf_pkg::BYTE_DATA) begin
                        st_nxt.bytecnt = st_r.bytecnt + 2'h1;
                    end
                end
            end
            if (sel_now && sck_fall && rd_phase) begin
                st_nxt.so_oe_b = 1'b0;
                if (st_r.bitcnt == 3'h0) begin
                    st_nxt.so = rd_byte_i[7];
                    st_nxt.txreg = {rd_byte_i[6:0], 1'b0};
                    st_nxt.rd_req = 1'b1;
                end else begin
                    st_nxt.so = st_r.txreg[7];
                    st_nxt.txreg = {st_r.txreg[6:0], 1'b0};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_r <= '0;
            st_r.opcode <= sspf_pkg::OPCODE_RST;
            st_r.so_oe_b <= 1'b1;
            st_r.cnt <= RESTORE_CYC[15:0];
            st_r.busy <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign so_o = st_r.so;
    assign so_oe_b_o = st_r.so_oe_b;
    assign rd_req_o = st_r.rd_req;
    assign opcode_o = st_r.opcode;
    assign opcode_vld_o = st_r.op_vld;
    assign byte_o = st_r.rx_byte;
    assign byte_vld_o = st_r.byte_vld;
    assign wr_commit_o = st_r.commit;
    assign busy_o = st_r.busy;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_b_i);

    sequence s_desel;
        cs_hi;
    endsequence
    sequence s_idle_after;
        !st_r.sel && st_r.bitcnt == 3'h0 && st_r.bytecnt == 2'h0;
    endsequence

    property p_sel_only;
        cs_hi && sck_rise |=> $stable(st_r.shreg);
    endproperty
    a_sel_only: assert property (p_sel_only) else $error("shift while deselected");

    property p_desel;
        s_desel |=> s_idle_after;
    endproperty
    a_desel: assert property (p_desel) else $error("frame not ended on deselect");

    property p_hiz;
        s_desel |=> so_oe_b_o ##1 (so_oe_b_o || !cs_hi);
    endproperty
    a_hiz: assert property (p_hiz) else $error("output driven while deselected");

    property p_commit;
        wr_commit_o |-> $past(cs_rise) && $past(st_r.wr_pend);
    endproperty
    a_commit: assert property (p_commit) else $error("commit without select rise");

    property p_arm;
        !st_r.armed && !cs_fall && sck_rise |=> $stable(st_r.bitcnt);
    endproperty
    a_arm: assert property (p_arm) else $error("bus used before select fall");

    property p_sample;
        sel_now && sck_rise |=> st_r.shreg[0] == $past(si_s);
    endproperty
    a_sample: assert property (p_sample) else $error("input bit not sampled");

    property p_out_edge;
        !$stable(so_o) && !so_oe_b_o |-> $past(sck_fall);
    endproperty
    a_out_edge: assert property (p_out_edge) else $error("output moved off falling edge");

    property p_recall;
        recall_req_i && !busy_o |=> busy_o && st_r.cnt == RECALL_CYC[15:0];
    endproperty
    a_recall: assert property (p_recall) else $error("recall length wrong");

    property p_restore;
        st_r.cnt <= RESTORE_CYC && busy_o == (st_r.cnt != 16'h0000);
    endproperty
    a_restore: assert property (p_restore) else $error("busy counter out of range");

    property p_opcode;
        opcode_vld_o |-> st_r.bytecnt == 2'h1 && opcode_o == $past(rx_val);
    endproperty
    a_opcode: assert property (p_opcode) else $error("opcode not first msb-first byte");

endmodule : sspf_frame

// ===== bench/sspf_host_model.sv
// spi master model in mode 0 facing the serial framing block
// assumes its tasks are called from the bench on mclk rising edges
`timescale 1ns/100ps

module sspf_host_model #(
    parameter int HALF = 5
) (
    // clock
    input wire logic mclk_i,
    // serial pins
    input wire logic so_i,
    output logic cs_b_o,
    output logic sck_o,
    output logic si_o
);
    // sck stands low outside frames
    initial begin
        cs_b_o = 1'b1;
        sck_o = 1'b0;
        si_o = 1'b0;
    end

    task automatic hold_off(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : hold_off

    // every frame opens on a fresh falling select edge
    task automatic select();
        cs_b_o <= 1'b0;
        hold_off(HALF);
    endtask : select

    task automatic deselect();
        sck_o <= 1'b0;
        hold_off(HALF);
        cs_b_o <= 1'b1;
        hold_off(2 * HALF);
    endtask : deselect

    // nbits below 8 leaves a partial byte on the wire
    task automatic xfer(input logic [7:0] tx, input int nbits,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 0; i < nbits; i++) begin
            sck_o <= 1'b0;
            si_o <= tx[7 - i];
            hold_off(HALF);
            sck_o <= 1'b1;
            rx = {rx[6:0], so_i};
            hold_off(HALF);
        end
    endtask : xfer
endmodule : sspf_host_model

// ===== bench/tb_top.sv
// self-checking bench for the serial framing block
// assumes short restore and recall counts set through parameters
`timescale 1ns/100ps

module tb_top;
    localparam int RST_CYC = 40;
    localparam int RCL_CYC = 20;
    localparam int LIMIT = 20000;
    logic mclk_i;
    logic rst_b_i;
    logic recall_req_i;
    logic [7:0] rd_byte_i;
    logic cs_b, sck, si, so_o, so_oe_b_o, rd_req_o;
    logic opcode_vld_o, byte_vld_o, wr_commit_o, busy_o;
    logic [7:0] opcode_o, byte_o, rx;
    logic [7:0] got_q[$];
    logic [7:0] rd_tab[4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    int rd_idx = 0;
    int commit_cnt = 0;
    int fail_count = 0;
    int compares = 0;
    int cyc = 0;
    // a released output line floats up through the bus pull-up
    logic so_line;
    assign so_line = so_oe_b_o ? 1'b1 : so_o;

    sspf_frame #(.RECALL_CYC(RCL_CYC), .RESTORE_CYC(RST_CYC)) i_sspf_frame (
        .mclk_i(mclk_i), .rst_b_i(rst_b_i), .cs_b_i(cs_b), .sck_i(sck),
        .si_i(si), .so_o(so_o), .so_oe_b_o(so_oe_b_o),
        .recall_req_i(recall_req_i), .rd_byte_i(rd_byte_i),
        .rd_req_o(rd_req_o), .opcode_o(opcode_o),
        .opcode_vld_o(opcode_vld_o), .byte_o(byte_o),
        .byte_vld_o(byte_vld_o), .wr_commit_o(wr_commit_o),
        .busy_o(busy_o));
    sspf_host_model i_sspf_host_model (
        .mclk_i(mclk_i), .so_i(so_line), .cs_b_o(cs_b), .sck_o(sck),
        .si_o(si));

    // ------------------------------------------------------------
    // monitor, read data feed and timeout
    // ------------------------------------------------------------
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (opcode_vld_o === 1'b1) got_q.push_back(opcode_o);
        if (byte_vld_o === 1'b1) got_q.push_back(byte_o);
        if (wr_commit_o === 1'b1) commit_cnt <= commit_cnt + 1;
        if (rd_req_o === 1'b1) begin
            rd_idx <= rd_idx + 1;
            rd_byte_i <= rd_tab[(rd_idx + 1) % 4];
        end
        if (cyc == LIMIT) begin
            fail_count++;
            wrap_up();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tx(input logic [7:0] b);
        i_sspf_host_model.xfer(b, 8, rx);
    endtask : tx

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic s_restore();
        i_sspf_host_model.select();
        i_sspf_host_model.hold_off(30);
        check(8'(busy_o), 8'h01);
        i_sspf_host_model.hold_off(10);
        check(8'(busy_o), 8'h00);
        tx(sspf_pkg::OP_WRITE);
        i_sspf_host_model.deselect();
        check(8'(got_q.size()), 8'h00);
        tx(sspf_pkg::OP_READ);
        i_sspf_host_model.deselect();
        check(8'(got_q.size()), 8'h00);
    endtask : s_restore

    task automatic s_write();
        logic [7:0] wr[5] = '{sspf_pkg::OP_WRITE, 8'h12, 8'h34, 8'hC9, 8'h5A};
        i_sspf_host_model.select();
        foreach (wr[i]) tx(wr[i]);
        check(opcode_o, sspf_pkg::OP_WRITE);
        check(8'(commit_cnt), 8'h00);
        i_sspf_host_model.deselect();
        check(8'(got_q.size()), 8'h05);
        foreach (wr[i]) check(got_q[i], wr[i]);
        check(8'(commit_cnt), 8'h01);
        check(opcode_o, 8'h00);
        check(8'(so_oe_b_o), 8'h01);
    endtask : s_write

    task automatic s_read();
        got_q.delete();
        i_sspf_host_model.select();
        tx(sspf_pkg::OP_READ);
        tx(8'h00);
        tx(8'h10);
        check(rx, 8'hFF);
        for (int i = 0; i < 2; i++) begin
            tx(8'hFF);
            check(rx, rd_tab[i]);
        end
        check(8'(so_oe_b_o), 8'h00);
        i_sspf_host_model.deselect();
        check(8'(so_oe_b_o), 8'h01);
        check(got_q[0], sspf_pkg::OP_READ);
        check(got_q[2], 8'h10);
        check(8'(commit_cnt), 8'h01);
    endtask : s_read

    // a write with no data byte and a partial byte must not commit
    task automatic s_partial();
        got_q.delete();
        i_sspf_host_model.select();
        tx(sspf_pkg::OP_WRITE);
        tx(8'h00);
        tx(8'h01);
        i_sspf_host_model.xfer(8'hAA, 5, rx);
        i_sspf_host_model.deselect();
        check(8'(commit_cnt), 8'h01);
        check(8'(got_q.size()), 8'h03);
        i_sspf_host_model.select();
        tx(8'h96);
        i_sspf_host_model.deselect();
        check(got_q[3], 8'h96);
    endtask : s_partial

    task automatic s_recall();
        got_q.delete();
        recall_req_i <= 1'b1;
        @(posedge mclk_i);
        recall_req_i <= 1'b0;
        i_sspf_host_model.select();
        check(8'(busy_o), 8'h01);
        i_sspf_host_model.hold_off(10);
        check(8'(busy_o), 8'h01);
        i_sspf_host_model.hold_off(8);
        check(8'(busy_o), 8'h00);
        tx(8'h3C);
        i_sspf_host_model.deselect();
        // already armed, so the frame opened during recall runs once
        // busy has ended
        check(8'(got_q.size()), 8'h01);
        i_sspf_host_model.select();
        tx(8'h3C);
        i_sspf_host_model.deselect();
        check(got_q[0], 8'h3C);
        check(got_q[1], 8'h3C);
    endtask : s_recall

    task automatic wrap_up();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        mclk_i = 1'b0;
        forever #4 mclk_i = ~mclk_i;
    end

    initial begin
        rst_b_i = 1'b0;
        recall_req_i = 1'b0;
        rd_byte_i = 8'hA5;
        repeat (6) @(posedge mclk_i);
        rst_b_i <= 1'b1;
        s_restore();
        s_write();
        s_read();
        s_partial();
        s_recall();
        wrap_up();
    end
endmodule : tb_top
